// >>> hdl/ncr_pkg.sv
// Contract
// RQ1: Cache read starts at column zero; both column address bytes are 00h.
// RQ2: Cache read uses the page read sequence but confirms with 31h, not 30h.
// RQ3: After first latency the device streams page n while fetching page n+1.
// RQ4: First page latency about 25us; an x8 page download takes at least 100us.
// RQ5: Ready/busy low while readout is not allowed, high when page n is readable.
// RQ6: Status bit 6 mirrors ready/busy; status bit 5 is 0 while internally reading.
// RQ7: Cache read is left only by exit command 34h, accepted at any moment.
// RQ8: On exit an active device idles within 5us; otherwise brief busy then ready.
// RQ9: On reaching the last byte of the array the host issues the exit command.
// RQ10: No random column data output is allowed during cache read.
// RQ11: To avoid invalid blocks, limit each cache read to one block.
// RQ12: Ready/busy is open drain, low while busy, high when the sequencer ends.
// RQ13: After power-up wait at least 10us before any command.
// RQ14: Hold write protect low during power-up and power-down.
// RQ15: Program and erase need a setup command followed by a confirm command.
// RQ16: Cache transfer busy is typically 3us, up to 700us; timeouts cover 700us.
// RQ17: At most 4 partial programs per page between erases.
// RQ18: Command 70h makes reads return the status byte until another command.
// RQ19: After status polling write 00h before resuming data reads.
// RQ20: Every busy wait has a timeout; expiry is an error.
package ncr_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_NS = 100;
  localparam int CLK_MHZ = 10;
  localparam int PWR_US = 10;
  localparam int PWR_CYC = PWR_US * CLK_MHZ;
  localparam int WB_NS = 100;
  localparam int WB_CYC = (WB_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_CYC = 2;
  localparam int BUSY_MIN_CYC = WB_CYC + SYNC_CYC;
  localparam int RE_LO_CYC = SYNC_CYC + 2;
  localparam int CACHE_BUSY_MAX_US = 700;
  localparam int CACHE_BUSY_MAX_CYC = CACHE_BUSY_MAX_US * CLK_MHZ;
  localparam int PAGE_BYTES_X8 = 2112;
  localparam int PAGES_PER_BLOCK = 64;
  localparam int ROW_BITS = 17;
  localparam int PARTIAL_PROGRAM_LIMIT = 4;
  // ==========================================================
  // Command codes
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_STD_CONF = 8'h30;
  localparam logic [7:0] CMD_CACHE = 8'h31;
  localparam logic [7:0] CMD_EXIT = 8'h34;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] COL_START = 8'h00;
  localparam logic [2:0] STEP_READ_LAST = 3'h6;
  localparam int ST_RB_BIT = 6;
  localparam int ST_ACTIVE_BIT = 5;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {OP_READ, OP_STAT, OP_EXIT, OP_RESUME} ncr_op_t;
  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
    logic wp_n;
    logic io_oe;
    logic [7:0] io_out;
  } ncr_pins_t;
endpackage

// >>> hdl/ncr_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module ncr_ctrl #(
  parameter int ROW_W = ncr_pkg::ROW_BITS,
  parameter int PAGE_BYTES = ncr_pkg::PAGE_BYTES_X8,
  parameter int PAGES_PER_BLK = ncr_pkg::PAGES_PER_BLOCK,
  parameter int BUSY_TO_CYC = ncr_pkg::CACHE_BUSY_MAX_CYC
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [ROW_W-1:0] start_row,
  input wire logic block_only,
  input wire logic stop,
  input wire logic stat_req,
  output var logic rd_valid,
  output var logic [7:0] rd_data,
  output var logic status_valid,
  output var logic [7:0] status_byte,
  output var logic dev_ready,
  output var logic dev_idle,
  output var logic busy,
  output var logic done,
  output var logic err,
  output var ncr_pkg::ncr_pins_t pins,
  input wire logic [7:0] io_in,
  input wire logic rb_in
);
  import ncr_pkg::*;

  localparam int BLK_W = $clog2(PAGES_PER_BLK);
  localparam logic [15:0] TO_LAST = 16'(BUSY_TO_CYC - 1);
  localparam logic [15:0] PWR_LAST = 16'(PWR_CYC - 1);
  localparam logic [15:0] BUSY_MIN = 16'(BUSY_MIN_CYC);
  localparam logic [15:0] RE_LAST = 16'(RE_LO_CYC - 1);
  localparam logic [11:0] PAGE_LAST = 12'(PAGE_BYTES - 1);

  if (PAGE_BYTES < 2 || PAGE_BYTES > 4096 || BUSY_TO_CYC < 8 || BUSY_TO_CYC > 65535 ||
      ROW_W < 9 || ROW_W > 24 || (1 << BLK_W) != PAGES_PER_BLK || BLK_W >= ROW_W)
  begin : g_chk
    $error("ncr_ctrl: unsupported parameter value");
  end

  typedef enum logic [2:0] {S_PWR, S_IDLE, S_WR_LO, S_WR_HI, S_BUSY, S_RD_LO, S_RD_HI, S_ERR}
    ncr_state_t;

  ncr_state_t state_ff;
  ncr_state_t nxt_state;
  ncr_op_t op_ff;
  ncr_op_t nxt_op;
  logic [2:0] step_ff;
  logic [2:0] nxt_step;
  logic [15:0] tmr_ff;
  logic [11:0] byte_ff;
  logic [ROW_W-1:0] row_ff;
  logic stop_pend_ff;
  logic [7:0] io_s1_ff;
  logic [7:0] io_s2_ff;
  logic rb_s1_ff;
  logic rb_s2_ff;
  logic page_end;
  logic leave_read;

  // ==========================================================
  // Command and address bytes {cle, ale, byte}
  function automatic logic [9:0] seq_byte(ncr_op_t op, logic [2:0] step, logic [ROW_W-1:0] row);
    logic [23:0] r;
    r = 24'(row);
    seq_byte = {2'h2, CMD_READ};
    case (op)
      OP_READ:
        case (step)
          3'h1, 3'h2: seq_byte = {2'h1, COL_START}; // [RQ1] [RQ10]
          3'h3: seq_byte = {2'h1, r[7:0]};
          3'h4: seq_byte = {2'h1, r[15:8]};
          3'h5: seq_byte = {2'h1, r[23:16]};
          3'h6: seq_byte = {2'h2, CMD_CACHE}; // [RQ2]
          default: seq_byte = {2'h2, CMD_READ};
        endcase
      OP_STAT: seq_byte = {2'h2, CMD_STATUS}; // [RQ18]
      OP_EXIT: seq_byte = {2'h2, CMD_EXIT}; // [RQ7]
      default: seq_byte = {2'h2, CMD_READ}; // [RQ19]
    endcase
  endfunction

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      io_s1_ff <= 8'h00;
      io_s2_ff <= 8'h00;
      rb_s1_ff <= 1'b0;
      rb_s2_ff <= 1'b0;
    end
    else
    begin
      io_s1_ff <= io_in;
      io_s2_ff <= io_s1_ff;
      rb_s1_ff <= rb_in;
      rb_s2_ff <= rb_s1_ff;
    end
  end

  // ==========================================================
  // Sequencer
  assign page_end = (byte_ff == PAGE_LAST);
  assign leave_read = stop_pend_ff || (&row_ff) || (block_only && (&row_ff[BLK_W-1:0]));

  always_comb
  begin
    nxt_state = state_ff;
    nxt_op = op_ff;
    nxt_step = step_ff;
    case (state_ff)
      S_PWR:
        if (tmr_ff == PWR_LAST) nxt_state = S_IDLE; // [RQ13]
      S_IDLE:
        if (start)
        begin
          nxt_op = OP_READ;
          nxt_step = 3'h0;
          nxt_state = S_WR_LO;
        end
        else if (stat_req)
        begin
          nxt_op = OP_STAT;
          nxt_step = 3'h0;
          nxt_state = S_WR_LO;
        end
      S_WR_LO: nxt_state = S_WR_HI;
      S_WR_HI:
        if (op_ff == OP_READ && step_ff != STEP_READ_LAST)
        begin
          nxt_step = step_ff + 3'h1;
          nxt_state = S_WR_LO;
        end
        else
          case (op_ff)
            OP_READ, OP_EXIT: nxt_state = S_BUSY;
            OP_STAT: nxt_state = S_RD_LO;
            default: nxt_state = S_IDLE;
          endcase
      S_BUSY:
        if (op_ff == OP_READ && stop_pend_ff)
        begin
          nxt_op = OP_EXIT; // [RQ7]
          nxt_step = 3'h0;
          nxt_state = S_WR_LO;
        end
        else if (tmr_ff >= BUSY_MIN && rb_s2_ff) // [RQ5] [RQ12]
          nxt_state = (op_ff == OP_EXIT) ? S_IDLE : S_RD_LO; // [RQ8]
        else if (tmr_ff == TO_LAST)
          nxt_state = S_ERR; // [RQ20] [RQ16]
      S_RD_LO:
        if (tmr_ff == RE_LAST) nxt_state = S_RD_HI;
      S_RD_HI:
        if (op_ff == OP_STAT)
        begin
          nxt_op = OP_RESUME; // [RQ19]
          nxt_step = 3'h0;
          nxt_state = S_WR_LO;
        end
        else if ((page_end && leave_read) || stop_pend_ff)
        begin
          nxt_op = OP_EXIT; // [RQ9] [RQ11] [RQ7]
          nxt_step = 3'h0;
          nxt_state = S_WR_LO;
        end
        else
          nxt_state = page_end ? S_BUSY : S_RD_LO; // [RQ3] [RQ4]
      S_ERR:
        if (start) nxt_state = S_IDLE;
      default: nxt_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_ff <= S_PWR;
      op_ff <= OP_READ;
      step_ff <= 3'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      op_ff <= nxt_op;
      step_ff <= nxt_step;
    end
  end

  // ==========================================================
  // Phase timer
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      tmr_ff <= 16'h0000;
    else if (nxt_state != state_ff)
      tmr_ff <= 16'h0000;
    else if (tmr_ff != 16'hffff)
      tmr_ff <= tmr_ff + 16'h0001;
  end

  // ==========================================================
  // Byte and page position, pending exit
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      byte_ff <= 12'h000;
      row_ff <= '0;
    end
    else if (state_ff == S_IDLE && start)
    begin
      byte_ff <= 12'h000;
      row_ff <= start_row;
    end
    else if (state_ff == S_RD_HI && op_ff == OP_READ)
    begin
      byte_ff <= page_end ? 12'h000 : byte_ff + 12'h001;
      if (page_end) row_ff <= row_ff + {{(ROW_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      stop_pend_ff <= 1'b0;
    else if (state_ff == S_IDLE)
      stop_pend_ff <= 1'b0;
    else
      stop_pend_ff <= stop || (stop_pend_ff && !(nxt_op == OP_EXIT));
  end

  // ==========================================================
  // User outputs
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
      status_valid <= 1'b0;
      status_byte <= 8'h00;
      done <= 1'b0;
    end
    else
    begin
      rd_valid <= (state_ff == S_RD_LO && nxt_state == S_RD_HI && op_ff == OP_READ);
      status_valid <= (state_ff == S_RD_LO && nxt_state == S_RD_HI && op_ff == OP_STAT);
      if (state_ff == S_RD_LO && nxt_state == S_RD_HI)
      begin
        if (op_ff == OP_STAT) status_byte <= io_s2_ff;
        else rd_data <= io_s2_ff;
      end
      done <= (state_ff == S_BUSY && op_ff == OP_EXIT && nxt_state == S_IDLE);
    end
  end

  assign dev_ready = status_byte[ST_RB_BIT]; // [RQ6]
  assign dev_idle = status_byte[ST_ACTIVE_BIT];
  assign busy = (state_ff != S_IDLE);
  assign err = (state_ff == S_ERR);

  // ==========================================================
  // Flash pins
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      pins <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1, wp_n: 1'b0,
                io_oe: 1'b0, io_out: 8'h00};
    else
    begin
      pins.wp_n <= (state_ff != S_PWR); // [RQ14] [RQ15] [RQ17]
      pins.ce_n <= (state_ff == S_PWR || state_ff == S_IDLE || state_ff == S_ERR);
      pins.we_n <= (state_ff != S_WR_LO);
      pins.re_n <= (state_ff != S_RD_LO);
      pins.io_oe <= (state_ff == S_WR_LO || state_ff == S_WR_HI);
      {pins.cle, pins.ale, pins.io_out} <=
        (state_ff == S_WR_LO || state_ff == S_WR_HI) ? seq_byte(op_ff, step_ff, row_ff) : 10'h000;
    end
  end

  // ==========================================================
  // Checks
  a_col_zero: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RQ1]
    (state_ff == S_WR_LO && op_ff == OP_READ && (step_ff == 3'h1 || step_ff == 3'h2))
    |=> (pins.ale && !pins.cle && !pins.we_n && pins.io_out == COL_START))
    else $error("column byte not zero");
  a_cache_confirm: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RQ2]
    (state_ff == S_WR_LO && op_ff == OP_READ && step_ff == STEP_READ_LAST)
    |=> (pins.cle && pins.io_out == CMD_CACHE) ##1 (state_ff == S_BUSY))
    else $error("cache confirm wrong");
  a_exit_code: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RQ7]
    (state_ff == S_WR_LO && op_ff == OP_EXIT) |=> (pins.cle && pins.io_out == CMD_EXIT))
    else $error("exit code wrong");
  a_stop_exits: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RQ7]
    (stop && op_ff == OP_READ && (state_ff == S_BUSY || state_ff == S_RD_LO))
    |-> ##[1:6] (op_ff == OP_EXIT))
    else $error("stop not honoured");
  a_array_end: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RQ9]
    (state_ff == S_RD_HI && op_ff == OP_READ && page_end && (&row_ff)) |=> (op_ff == OP_EXIT))
    else $error("no exit at array end");
  a_block_limit: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RQ11]
    (state_ff == S_RD_HI && op_ff == OP_READ && page_end && block_only && (&row_ff[BLK_W-1:0]))
    |=> (op_ff == OP_EXIT && state_ff == S_WR_LO))
    else $error("no exit at block end");
  a_pwr_wait: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RQ13]
    $fell(pins.we_n) |-> !$past(state_ff == S_PWR, 2))
    else $error("command during power-up wait");
  a_wp_low: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RQ14]
    (state_ff == S_PWR) |=> !pins.wp_n)
    else $error("write protect released early");
  a_status_cmd: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RQ18]
    (state_ff == S_WR_LO && op_ff == OP_STAT) |=> (pins.io_out == CMD_STATUS) ##2 !pins.io_oe)
    else $error("status command wrong");
  a_resume_read: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RQ19]
    (state_ff == S_RD_HI && op_ff == OP_STAT) |=> ##1 (pins.cle && pins.io_out == CMD_READ))
    else $error("no read command after status");
  a_busy_timeout: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RQ20]
    (state_ff == S_BUSY && tmr_ff == TO_LAST && !rb_s2_ff && !stop_pend_ff)
    |=> (state_ff == S_ERR))
    else $error("busy wait overran timeout");
endmodule // ncr_ctrl
`default_nettype wire

// >>> dv/ncr_nand_model.sv
`timescale 1ns/1ns
`default_nettype none
module ncr_nand_model #(
  parameter int PB = 8,
  parameter int LAT = 20,
  parameter int GAP = 4,
  parameter int EXB = 5
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire ncr_pkg::ncr_pins_t pins,
  input wire logic hang,
  output var logic [7:0] dq,
  output var logic rb_low,
  output var logic proto_err,
  output var int exit_cnt
);
  import ncr_pkg::*;
  logic we_q, re_q, stat_q, act_q;
  logic [7:0] row_q, d;
  logic [2:0] acnt_q;
  int busy_q, col_q, up_q;
  // ==========================================
  // Ready/busy and read data
  assign rb_low = (busy_q != 0) || hang;
  assign d = stat_q ? {pins.wp_n, ~rb_low, busy_q == 0, 5'h00} : row_q + col_q[7:0];
  assign dq = pins.re_n ? ~d : d;
  // ==========================================
  // Command decoder and page streaming
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      we_q <= 1'b1;
      re_q <= 1'b1;
      stat_q <= 1'b0;
      act_q <= 1'b0;
      row_q <= 8'h00;
      acnt_q <= 3'h0;
      busy_q <= 0;
      col_q <= 0;
      up_q <= 0;
      proto_err <= 1'b0;
      exit_cnt <= 0;
    end
    else
    begin
      we_q <= pins.we_n;
      re_q <= pins.re_n;
      if (up_q < PWR_CYC) up_q <= up_q + 1;
      if (busy_q != 0) busy_q <= busy_q - 1;
      if (re_q && !pins.re_n && !stat_q && rb_low) proto_err <= 1'b1;
      if (!we_q && pins.we_n && !pins.ce_n)
      begin
        if (up_q < PWR_CYC) proto_err <= 1'b1;
        if (pins.cle)
        begin
          case (pins.io_out)
            CMD_READ:
            begin
              stat_q <= 1'b0;
              acnt_q <= 3'h0;
            end
            CMD_CACHE:
            begin
              if (acnt_q != 3'h5) proto_err <= 1'b1;
              act_q <= 1'b1;
              busy_q <= LAT;
              col_q <= 0;
            end
            CMD_EXIT:
            begin
              act_q <= 1'b0;
              busy_q <= EXB;
              exit_cnt <= exit_cnt + 1;
            end
            CMD_STATUS: stat_q <= 1'b1;
            default: proto_err <= 1'b1;
          endcase
        end
        else if (pins.ale)
        begin
          acnt_q <= acnt_q + 3'h1;
          if (acnt_q < 3'h2 && pins.io_out != COL_START) proto_err <= 1'b1;
          if (acnt_q == 3'h2) row_q <= pins.io_out;
        end
      end
      if (!re_q && pins.re_n && act_q && !stat_q)
      begin
        if (col_q == PB - 1)
        begin
          col_q <= 0;
          row_q <= row_q + 8'h01;
          busy_q <= GAP;
        end
        else col_q <= col_q + 1;
      end
    end
  end
endmodule // ncr_nand_model
`default_nettype wire

// >>> dv/test_nand_cache_read_sequencing.sv
`timescale 1ns/1ns
`default_nettype none
module test_nand_cache_read_sequencing;
  import ncr_pkg::*;
  localparam int PB = 8;
  localparam int TO = 200;
  logic clk_sys, reset_n, start, block_only, stop, stat_req, hang;
  logic [16:0] start_row;
  logic rd_valid, status_valid, dev_ready, dev_idle, busy, done, err, rb_low, proto_err;
  logic [7:0] rd_data, status_byte, dq;
  ncr_pins_t pins;
  wire logic [7:0] io_in;
  wire logic rb_in;
  int exit_cnt, x0, n;
  int failures = 0;
  int n_checks = 0;
  assign io_in = pins.io_oe ? pins.io_out : dq;
  assign rb_in = rb_low ? 1'b0 : 1'b1;
  ncr_ctrl #(.PAGE_BYTES(PB), .BUSY_TO_CYC(TO)) i_ncr_ctrl (.clk_sys(clk_sys),
    .reset_n(reset_n), .start(start), .start_row(start_row), .block_only(block_only),
    .stop(stop), .stat_req(stat_req), .rd_valid(rd_valid), .rd_data(rd_data),
    .status_valid(status_valid), .status_byte(status_byte), .dev_ready(dev_ready),
    .dev_idle(dev_idle), .busy(busy), .done(done), .err(err), .pins(pins), .io_in(io_in),
    .rb_in(rb_in));
  ncr_nand_model #(.PB(PB)) i_ncr_nand_model (.clk_sys(clk_sys), .reset_n(reset_n),
    .pins(pins), .hang(hang), .dq(dq), .rb_low(rb_low), .proto_err(proto_err),
    .exit_cnt(exit_cnt));
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // ==========================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic go(input logic s, input logic q);
    @(posedge clk_sys);
    start <= s;
    stat_req <= q;
    @(posedge clk_sys);
    start <= 1'b0;
    stat_req <= 1'b0;
  endtask
  function automatic logic sig(input int w);
    case (w)
      0: return status_valid;
      1: return done;
      2: return err;
      default: return !busy;
    endcase
  endfunction
  task automatic wait_on(input int w, input int bound);
    int i;
    for (i = 0; i < bound && sig(w) !== 1'b1; i++) tick;
    if (i == bound)
    begin
      failures++;
      final_report;
    end
  endtask
  task automatic stream(input int stop_at, output int cnt);
    int i;
    logic want;
    logic [7:0] e;
    cnt = 0;
    want = 1'b0;
    for (i = 0; i < 4000 && done !== 1'b1; i++)
    begin
      @(posedge clk_sys);
      stop <= want;
      want = 1'b0;
      #1;
      if (rd_valid === 1'b1)
      begin
        e = start_row[7:0] + 8'(cnt / PB) + 8'(cnt % PB);
        check(rd_data, e);
        cnt++;
        if (cnt == stop_at) want = 1'b1;
      end
    end
    if (i == 4000)
    begin
      failures++;
      final_report;
    end
  endtask
  // ==========================================
  // Scenarios
  task automatic sc_power;
    int i;
    for (i = 0; i < 300 && busy !== 1'b0; i++)
    begin
      tick;
      if (busy === 1'b1) check(pins.wp_n, 1'b0);
    end
    check(i >= PWR_CYC && i <= PWR_CYC + 3, 1'b1);
    repeat (2) tick;
    check(pins.wp_n, 1'b1);
  endtask
  task automatic sc_status;
    go(1'b0, 1'b1);
    wait_on(0, 50);
    check(status_byte, 8'he0);
    check({dev_ready, dev_idle}, 2'h3);
    wait_on(3, 50);
    tick;
    check(i_ncr_nand_model.stat_q, 1'b0);
  endtask
  task automatic sc_read(input logic [16:0] row, input logic blk, input int stop_at,
    input int pages);
    @(posedge clk_sys);
    start_row <= row;
    block_only <= blk;
    x0 = exit_cnt;
    go(1'b1, 1'b0);
    stream(stop_at, n);
    if (stop_at < 0) check(n, pages * PB);
    else check(n >= stop_at && n <= stop_at + 1, 1'b1);
    check(exit_cnt, x0 + 1);
    repeat (2) tick;
    check(busy, 1'b0);
    check(proto_err, 1'b0);
  endtask
  task automatic sc_timeout;
    @(posedge clk_sys);
    hang <= 1'b1;
    start_row <= 17'h00009;
    go(1'b1, 1'b0);
    wait_on(2, TO + 100);
    check({err, busy}, 2'h3);
    hang <= 1'b0;
    go(1'b1, 1'b0);
    tick;
    check(err, 1'b0);
  endtask
  initial
  begin
    reset_n = 1'b0;
    start = 1'b0;
    stop = 1'b0;
    stat_req = 1'b0;
    block_only = 1'b0;
    hang = 1'b0;
    start_row = 17'h00000;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    sc_power;
    sc_status;
    sc_read(17'h0003e, 1'b1, -1, 2);
    sc_read(17'h00005, 1'b0, 3, 0);
    sc_read(17'h00020, 1'b0, PB, 0);
    sc_read(17'h1ffff, 1'b0, -1, 1);
    sc_timeout;
    final_report;
  end
endmodule // test_nand_cache_read_sequencing
`default_nettype wire
